//--- src/rco_offload.v
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "rco_map.vh"

module rco_offload (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // register port
  input wire [`RCO_ADDR_W-1:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // mac receive stream in
  input wire rx_valid_i,
  input wire [7:0] rx_data_i,
  input wire rx_fcs_i,
  input wire rx_stat_valid_i,
  input wire [31:0] rx_stat_i,
  output reg rx_ready_o,
  // receive fifo stream out
  output reg rx_valid_o,
  output reg [7:0] rx_data_o,
  output reg rx_stat_valid_o,
  output reg [31:0] rx_stat_o,
  // transmit fifo stream in
  input wire tx_valid_i,
  input wire [7:0] tx_data_i,
  input wire tx_first_i,
  input wire tx_last_i,
  output reg tx_ready_o,
  // transmit stream to mac
  output reg tx_valid_o,
  output reg [7:0] tx_data_o,
  output reg tx_first_o,
  output reg tx_last_o
);

localparam [1:0] R_FRAME = 2'h0;
localparam [1:0] R_APP_LO = 2'h1;
localparam [1:0] R_APP_HI = 2'h2;
localparam [1:0] R_STAT = 2'h3;

localparam [2:0] T_CMD = 3'h0;
localparam [2:0] T_PRE = 3'h1;
localparam [2:0] T_PASS = 3'h2;
localparam [2:0] T_BUF = 3'h3;
localparam [2:0] T_FIN = 3'h4;
localparam [2:0] T_PLAY = 3'h5;

// a literal cannot be bit-selected, so the reset word gets a name first
localparam [31:0] CTRL_RST = `RCO_CTRL_RESET;

// end-around carry add, one fold is enough for two 16-bit operands
function [15:0] rco_add;
  input [15:0] a;
  input [15:0] b;
  reg [16:0] s;
  begin
    s = {1'b0, a} + {1'b0, b};
    rco_add = s[15:0] + {15'h0000, s[16]};
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers

reg rx_en_r;
reg rx_mode_r;
reg tx_en_r;
reg tx_mode_r;
reg [15:0] vlan_type_r;
reg [15:0] rx_done_cnt_r;
reg [15:0] tx_done_cnt_r;

always @(posedge mclk_i)
begin
  if (rst_i)
  begin
    rx_en_r <= CTRL_RST[`RCO_RX_SUM_ENABLE_BIT];
    rx_mode_r <= CTRL_RST[`RCO_RX_SUM_MODE_SEL_BIT];
    tx_en_r <= CTRL_RST[`RCO_TX_SUM_ENABLE_BIT];
    tx_mode_r <= CTRL_RST[`RCO_TX_SUM_MODE_SEL_BIT];
    vlan_type_r <= `RCO_VLAN_TYPE_RESET;
    reg_rdata_o <= 32'h0000_0000;
  end
  else
  begin
    if (reg_wr_i && reg_addr_i == `RCO_OFFLOAD_CONTROL_REG)
    begin
      // no interlock: software flushes both paths first
      rx_en_r <= reg_wdata_i[`RCO_RX_SUM_ENABLE_BIT];
      rx_mode_r <= reg_wdata_i[`RCO_RX_SUM_MODE_SEL_BIT];
      tx_en_r <= reg_wdata_i[`RCO_TX_SUM_ENABLE_BIT];
      tx_mode_r <= reg_wdata_i[`RCO_TX_SUM_MODE_SEL_BIT];
    end
    if (reg_wr_i && reg_addr_i == `RCO_VLAN_TAG_TYPE_REG)
      vlan_type_r <= reg_wdata_i[15:0];
    reg_rdata_o <= 32'h0000_0000;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `RCO_OFFLOAD_CONTROL_REG:
        begin
          reg_rdata_o[`RCO_RX_SUM_ENABLE_BIT] <= rx_en_r;
          reg_rdata_o[`RCO_RX_SUM_MODE_SEL_BIT] <= rx_mode_r;
          reg_rdata_o[`RCO_TX_SUM_ENABLE_BIT] <= tx_en_r;
          reg_rdata_o[`RCO_TX_SUM_MODE_SEL_BIT] <= tx_mode_r;
        end
        `RCO_VLAN_TAG_TYPE_REG: reg_rdata_o <= {16'h0000, vlan_type_r};
        `RCO_SUM_COUNT_REG: reg_rdata_o <= {tx_done_cnt_r, rx_done_cnt_r};
        default: reg_rdata_o <= 32'h0000_0000;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// receive engine

reg [1:0] rx_st_r;
reg [11:0] rx_cnt_r;
reg [11:0] rx_tpos_r;
reg [11:0] rx_start_r;
reg rx_known_r;
reg [1:0] rx_tags_r;
reg [7:0] rx_prev_r;
reg rx_odd_r;
reg [7:0] rx_low_r;
reg [15:0] rx_sum_r;
reg [31:0] rx_stat_hold_r;

wire rx_take = rx_valid_i && rx_ready_o;
wire rx_stat_take = rx_stat_valid_i && rx_ready_o;
wire [15:0] rx_type = {rx_prev_r, rx_data_i};
wire rx_in_sum = rx_known_r && (rx_cnt_r >= rx_start_r) && !rx_fcs_i;
wire [15:0] rx_final = rx_odd_r ? rco_add(rx_sum_r, {8'h00, rx_low_r}) : rx_sum_r;
wire [13:0] rx_len_plus = rx_stat_i[`RCO_STAT_LEN_MSB:`RCO_STAT_LEN_LSB] + `RCO_SUM_APPEND_LEN;

always @(posedge mclk_i)
begin
  if (rst_i)
  begin
    rx_st_r <= R_FRAME;
    rx_cnt_r <= 12'h000;
    rx_tpos_r <= `RCO_TYPE_POS;
    rx_start_r <= 12'hfff;
    rx_known_r <= 1'b0;
    rx_tags_r <= 2'h0;
    rx_prev_r <= 8'h00;
    rx_odd_r <= 1'b0;
    rx_low_r <= 8'h00;
    rx_sum_r <= 16'h0000;
    rx_stat_hold_r <= 32'h0000_0000;
    rx_done_cnt_r <= 16'h0000;
    rx_ready_o <= 1'b1;
    rx_valid_o <= 1'b0;
    rx_data_o <= 8'h00;
    rx_stat_valid_o <= 1'b0;
    rx_stat_o <= 32'h0000_0000;
  end
  else
  begin
    rx_valid_o <= 1'b0;
    rx_stat_valid_o <= 1'b0;
    case (rx_st_r)
      R_FRAME:
      begin
        if (rx_take)
        begin
          rx_valid_o <= 1'b1;
          rx_data_o <= rx_data_i;
          rx_cnt_r <= rx_cnt_r + 12'h001;
          rx_prev_r <= rx_data_i;
          if (!rx_known_r && rx_cnt_r == rx_tpos_r + 12'h001)
          begin
            if (!rx_mode_r)
            begin
              rx_start_r <= `RCO_MAC_HDR_LEN;
              rx_known_r <= 1'b1;
            end
            else if (rx_type == vlan_type_r && rx_tags_r != `RCO_MAX_VLAN_TAGS)
            begin
              rx_tpos_r <= rx_tpos_r + `RCO_VLAN_TAG_LEN;
              rx_tags_r <= rx_tags_r + 2'h1;
            end
            else if (rx_type < `RCO_LEN_TYPE_MIN)
            begin
              // length field: llc plus snap header precede layer 3
              rx_start_r <= rx_cnt_r + 12'h001 + `RCO_SNAP_HDR_LEN;
              rx_known_r <= 1'b1;
            end
            else
            begin
              // a third tag id lands here and is taken as the type
              rx_start_r <= rx_cnt_r + 12'h001;
              rx_known_r <= 1'b1;
            end
          end
          if (rx_in_sum)
          begin
            rx_odd_r <= !rx_odd_r;
            if (!rx_odd_r)
              rx_low_r <= rx_data_i;
            else
              rx_sum_r <= rco_add(rx_sum_r, {rx_data_i, rx_low_r});
          end
        end
        else if (rx_stat_take)
        begin
          rx_cnt_r <= 12'h000;
          rx_tpos_r <= `RCO_TYPE_POS;
          rx_start_r <= 12'hfff;
          rx_known_r <= 1'b0;
          rx_tags_r <= 2'h0;
          rx_odd_r <= 1'b0;
          rx_sum_r <= 16'h0000;
          if (rx_en_r)
          begin
            // every frame gets a sum, short or not
            rx_valid_o <= 1'b1;
            rx_data_o <= rx_final[7:0];
            rx_low_r <= rx_final[15:8];
            rx_stat_hold_r <= rx_stat_i;
            rx_stat_hold_r[`RCO_STAT_LEN_MSB:`RCO_STAT_LEN_LSB] <= rx_len_plus;
            rx_ready_o <= 1'b0;
            rx_done_cnt_r <= rx_done_cnt_r + 16'h0001;
            rx_st_r <= R_APP_HI;
          end
          else
          begin
            rx_stat_valid_o <= 1'b1;
            rx_stat_o <= rx_stat_i;
          end
        end
      end
      R_APP_HI:
      begin
        rx_valid_o <= 1'b1;
        rx_data_o <= rx_low_r;
        rx_st_r <= R_STAT;
      end
      R_STAT:
      begin
        rx_stat_valid_o <= 1'b1;
        rx_stat_o <= rx_stat_hold_r;
        rx_ready_o <= 1'b1;
        rx_st_r <= R_FRAME;
      end
      default: rx_st_r <= R_FRAME;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// transmit engine

// whole packet is held since the result may land before the summed bytes
reg [7:0] tx_mem [0:`RCO_BUF_DEPTH-1];
reg [2:0] tx_st_r;
reg [3:0] tx_hdr_r;
reg tx_fs_r;
reg [31:0] tx_pre_r;
reg [11:0] tx_cnt_r;
reg [11:0] tx_len_r;
reg tx_odd_r;
reg [7:0] tx_low_r;
reg [15:0] tx_sum_r;
reg [15:0] tx_res_r;

wire tx_take = tx_valid_i && tx_ready_o;
wire [11:0] tx_start = tx_pre_r[11:0];
wire [11:0] tx_loc = tx_pre_r[27:16];

always @(posedge mclk_i)
begin
  if (tx_take && tx_st_r == T_BUF)
    tx_mem[tx_cnt_r[`RCO_BUF_AW-1:0]] <= tx_data_i;
end

always @(posedge mclk_i)
begin
  if (rst_i)
  begin
    tx_st_r <= T_CMD;
    tx_hdr_r <= 4'h0;
    tx_fs_r <= 1'b0;
    tx_pre_r <= 32'h0000_0000;
    tx_cnt_r <= 12'h000;
    tx_len_r <= 12'h000;
    tx_odd_r <= 1'b0;
    tx_low_r <= 8'h00;
    tx_sum_r <= 16'h0000;
    tx_res_r <= 16'h0000;
    tx_done_cnt_r <= 16'h0000;
    tx_ready_o <= 1'b1;
    tx_valid_o <= 1'b0;
    tx_data_o <= 8'h00;
    tx_first_o <= 1'b0;
    tx_last_o <= 1'b0;
  end
  else
  begin
    tx_valid_o <= 1'b0;
    tx_first_o <= 1'b0;
    tx_last_o <= 1'b0;
    case (tx_st_r)
      T_CMD:
      begin
        if (tx_take)
        begin
          tx_valid_o <= 1'b1;
          tx_data_o <= tx_data_i;
          tx_first_o <= tx_first_i;
          tx_hdr_r <= tx_first_i ? 4'h1 : tx_hdr_r + 4'h1;
          if (tx_first_i || tx_hdr_r == `RCO_CMDA_FS_BYTE)
            tx_fs_r <= tx_data_i[`RCO_CMDA_FS_BIT];
          if (tx_hdr_r == `RCO_CMD_LAST_BYTE && !tx_first_i)
          begin
            tx_cnt_r <= 12'h000;
            tx_odd_r <= 1'b0;
            tx_sum_r <= 16'h0000;
            // per-packet flag sits in command b, checked with fs and enable
            if (tx_en_r && tx_fs_r && tx_pre_r[0])
              tx_st_r <= T_PRE;
            else
              tx_st_r <= T_PASS;
          end
          if (tx_hdr_r == `RCO_CMDB_CK_BYTE)
            tx_pre_r[0] <= tx_data_i[`RCO_CMDB_CK_BIT];
        end
      end
      T_PRE:
      begin
        if (tx_take)
        begin
          // preamble bytes are swallowed, never sent
          tx_pre_r <= {tx_data_i, tx_pre_r[31:8]};
          tx_hdr_r <= tx_hdr_r + 4'h1;
          if (tx_hdr_r == `RCO_PRE_LAST_BYTE)
            tx_st_r <= T_BUF;
        end
      end
      T_PASS:
      begin
        if (tx_take)
        begin
          tx_valid_o <= 1'b1;
          tx_data_o <= tx_data_i;
          tx_last_o <= tx_last_i;
          if (tx_last_i)
            tx_st_r <= T_CMD;
        end
      end
      T_BUF:
      begin
        if (tx_take)
        begin
          tx_cnt_r <= tx_cnt_r + 12'h001;
          if (tx_cnt_r >= tx_start)
          begin
            // runs to the final byte of the packet
            tx_odd_r <= !tx_odd_r;
            if (!tx_odd_r)
              tx_low_r <= tx_data_i;
            else
              tx_sum_r <= rco_add(tx_sum_r, {tx_data_i, tx_low_r});
          end
          if (tx_last_i)
          begin
            tx_len_r <= tx_cnt_r;
            tx_ready_o <= 1'b0;
            tx_st_r <= T_FIN;
          end
        end
      end
      T_FIN:
      begin
        // odd tail: the byte just stored pairs with zero
        if (tx_odd_r)
          tx_res_r <= ~rco_add(tx_sum_r, {8'h00, tx_low_r});
        else
          tx_res_r <= ~tx_sum_r;
        tx_cnt_r <= 12'h000;
        tx_done_cnt_r <= tx_done_cnt_r + 16'h0001;
        tx_st_r <= T_PLAY;
      end
      T_PLAY:
      begin
        tx_valid_o <= 1'b1;
        tx_last_o <= (tx_cnt_r == tx_len_r);
        // zero result goes out as is, no substitution
        if (tx_cnt_r == tx_loc)
          tx_data_o <= tx_res_r[7:0];
        else if (tx_cnt_r == tx_loc + 12'h001)
          tx_data_o <= tx_res_r[15:8];
        else
          tx_data_o <= tx_mem[tx_cnt_r[`RCO_BUF_AW-1:0]];
        tx_cnt_r <= tx_cnt_r + 12'h001;
        if (tx_cnt_r == tx_len_r)
        begin
          tx_ready_o <= 1'b1;
          tx_st_r <= T_CMD;
        end
      end
      default: tx_st_r <= T_CMD;
    endcase
  end
end

endmodule // rco_offload

`default_nettype wire

//--- pkg/rco_map.vh
`ifndef RCO_MAP_VH
`define RCO_MAP_VH

// register byte addresses
`define RCO_ADDR_W 8
`define RCO_OFFLOAD_CONTROL_REG 8'h00
`define RCO_VLAN_TAG_TYPE_REG 8'h04
`define RCO_SUM_COUNT_REG 8'h08

// offload_control_reg fields
`define RCO_RX_SUM_ENABLE_BIT 0
`define RCO_RX_SUM_MODE_SEL_BIT 1
`define RCO_TX_SUM_ENABLE_BIT 16
`define RCO_TX_SUM_MODE_SEL_BIT 17

// reset values
`define RCO_CTRL_RESET 32'h0000_0000
`define RCO_VLAN_TYPE_RESET 16'h8100

// frame layout
`define RCO_MAC_HDR_LEN 12'h00e
`define RCO_TYPE_POS 12'h00c
`define RCO_VLAN_TAG_LEN 12'h004
`define RCO_SNAP_HDR_LEN 12'h008
`define RCO_MAX_VLAN_TAGS 2'h2
`define RCO_LEN_TYPE_MIN 16'h0600
`define RCO_SUM_APPEND_LEN 14'h0002

// receive status word length field
`define RCO_STAT_LEN_LSB 16
`define RCO_STAT_LEN_MSB 29

// command word flag positions (byte index, bit in byte)
`define RCO_CMDA_FS_BYTE 4'h1
`define RCO_CMDA_FS_BIT 5
`define RCO_CMDB_CK_BYTE 4'h5
`define RCO_CMDB_CK_BIT 6
`define RCO_CMD_LAST_BYTE 4'h7
`define RCO_PRE_LAST_BYTE 4'hb

// store-and-forward buffer
`define RCO_BUF_AW 11
`define RCO_BUF_DEPTH 2048

`endif

//--- dv/rco_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module rco_assertions (
  // clock, reset, registers
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // receive
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_stat_valid_i,
  input wire logic [31:0] rx_stat_i,
  input wire logic rx_ready_o,
  input wire logic rx_valid_o,
  input wire logic [7:0] rx_data_o,
  input wire logic rx_stat_valid_o,
  input wire logic [31:0] rx_stat_o,
  // transmit
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_first_i,
  input wire logic tx_ready_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_first_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic en_r;
  logic [15:0] vlan_r;
  wire logic rx_tk = rx_valid_i && rx_ready_o;
  wire logic st_tk = rx_stat_valid_i && rx_ready_o;
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the software view, so no peeking inside the design
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      en_r <= 1'b0;
      vlan_r <= 16'h8100;
    end
    else if (reg_wr_i && reg_addr_i == 8'h00)
      en_r <= reg_wdata_i[0];
    else if (reg_wr_i && reg_addr_i == 8'h04)
      vlan_r <= reg_wdata_i[15:0];
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_rx_byte_echo: assert property (rx_tk |=> rx_valid_o && rx_data_o == $past(rx_data_i))
    else $error("rx byte not forwarded");
  chk_sum_append: assert property (st_tk && en_r |=> rx_valid_o ##1 rx_valid_o ##1
    (rx_stat_valid_o && rx_stat_o[29:16] == $past(rx_stat_i[29:16], 3) + 14'h0002))
    else $error("sum or length missing");
  chk_rx_stall: assert property (st_tk && en_r |=> !rx_ready_o [*2] ##1 rx_ready_o)
    else $error("input taken while sum appended");
  chk_stat_pass: assert property (st_tk && !en_r |=> rx_stat_valid_o && rx_stat_o == $past(rx_stat_i))
    else $error("status altered while off");
  chk_off_quiet: assert property (!en_r && !rx_tk |=> !rx_valid_o)
    else $error("extra byte while off");
  chk_vlan_read: assert property (reg_rd_i && reg_addr_i == 8'h04 |=> reg_rdata_o == {16'h0, vlan_r})
    else $error("tag type read wrong");
  chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
  chk_tx_cmd_echo: assert property (tx_valid_i && tx_ready_o && tx_first_i |=>
    tx_valid_o && tx_first_o && tx_data_o == $past(tx_data_i))
    else $error("command byte not echoed");
  cover property (st_tk && en_r);
  cover property (st_tk && !en_r);
  cover property (tx_valid_o && tx_first_o);
endmodule // rco_assertions
bind rco_offload rco_assertions u_chk (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .rx_valid_i, .rx_data_i, .rx_stat_valid_i, .rx_stat_i, .rx_ready_o,
  .rx_valid_o, .rx_data_o, .rx_stat_valid_o, .rx_stat_o, .tx_valid_i, .tx_data_i, .tx_first_i,
  .tx_ready_o, .tx_valid_o, .tx_data_o, .tx_first_o);
`default_nettype wire

//--- dv/rco_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module rco_far_model (
  // clock and ready
  input wire logic mclk_i,
  input wire logic rx_ready_i,
  input wire logic tx_ready_i,
  // mac receive side
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_fcs_o,
  output logic rx_stat_valid_o,
  output logic [31:0] rx_stat_o,
  // host transmit side
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_first_o,
  output logic tx_last_o
);
  logic slow;
  initial
  begin
    slow = 1'b0;
    {rx_valid_o, rx_data_o, rx_fcs_o, rx_stat_valid_o, rx_stat_o} = '0;
    {tx_valid_o, tx_data_o, tx_first_o, tx_last_o} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // a byte is held until an edge sees ready; slow mode idles after each byte with bit 0 set
  task automatic rx_put(input logic [7:0] d, input logic f);
    rx_valid_o <= 1'b1;
    rx_data_o <= d;
    rx_fcs_o <= f;
    @(posedge mclk_i);
    while (rx_ready_i !== 1'b1)
      @(posedge mclk_i);
    if (slow && d[0])
    begin
      rx_valid_o <= 1'b0;
      rx_data_o <= ~d; // released lines must not keep the old byte
      @(posedge mclk_i);
    end
  endtask
  task automatic rx_end(input logic [31:0] s);
    rx_valid_o <= 1'b0;
    rx_fcs_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
    rx_stat_valid_o <= 1'b1;
    rx_stat_o <= s;
    @(posedge mclk_i);
    while (rx_ready_i !== 1'b1)
      @(posedge mclk_i);
    rx_stat_valid_o <= 1'b0;
    rx_stat_o <= ~s;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic tx_put(input logic [7:0] d, input logic fst, input logic lst);
    tx_valid_o <= 1'b1;
    tx_data_o <= d;
    tx_first_o <= fst;
    tx_last_o <= lst;
    @(posedge mclk_i);
    while (tx_ready_i !== 1'b1)
      @(posedge mclk_i);
    if (lst || (slow && d[0]))
    begin
      {tx_valid_o, tx_first_o, tx_last_o} <= 3'h0;
      tx_data_o <= ~d;
      @(posedge mclk_i);
    end
  endtask
endmodule // rco_far_model
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic mclk_i, rst_i, reg_wr_i, reg_rd_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, lfsr, r, cw;
  logic [15:0] vr;
  wire logic [31:0] reg_rdata_o, rx_stat_i, rx_stat_o;
  wire logic rx_valid_i, rx_fcs_i, rx_stat_valid_i, rx_ready_o, rx_valid_o, rx_stat_valid_o;
  wire logic [7:0] rx_data_i, rx_data_o, tx_data_i, tx_data_o;
  wire logic tx_valid_i, tx_first_i, tx_last_i, tx_ready_o, tx_valid_o, tx_first_o, tx_last_o;
  int fails, compares, cyc, nrx, ntx;
  logic [7:0] rq[$], tq[$], fr[$], exp[$];
  logic [1:0] tfq[$];
  logic [31:0] stq[$];
  rco_offload u_dut (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .rx_valid_i, .rx_data_i, .rx_fcs_i, .rx_stat_valid_i, .rx_stat_i, .rx_ready_o,
    .rx_valid_o, .rx_data_o, .rx_stat_valid_o, .rx_stat_o, .tx_valid_i, .tx_data_i, .tx_first_i,
    .tx_last_i, .tx_ready_o, .tx_valid_o, .tx_data_o, .tx_first_o, .tx_last_o);
  rco_far_model u_far (.mclk_i, .rx_ready_i(rx_ready_o), .tx_ready_i(tx_ready_o),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_fcs_o(rx_fcs_i),
    .rx_stat_valid_o(rx_stat_valid_i), .rx_stat_o(rx_stat_i), .tx_valid_o(tx_valid_i),
    .tx_data_o(tx_data_i), .tx_first_o(tx_first_i), .tx_last_o(tx_last_i));
  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cyc++;
    if (rx_valid_o === 1'b1) rq.push_back(rx_data_o);
    if (rx_stat_valid_o === 1'b1) stq.push_back(rx_stat_o);
    if (tx_valid_o === 1'b1) tq.push_back(tx_data_o);
    if (tx_valid_o === 1'b1) tfq.push_back({tx_first_o, tx_last_o});
    if (cyc > 40000)
    begin
      fails++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rb();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0] ^ lfsr[19:12];
  endfunction
  function automatic logic [15:0] csum(input int s, input int e);
    logic [16:0] a;
    a = '0;
    for (int i = s; i < e; i += 2)
      a = a[15:0] + a[16] + {(i + 1 < e) ? fr[i + 1] : 8'h00, fr[i]};
    a = a[15:0] + a[16];
    a = a[15:0] + a[16];
    return a[15:0];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string m);
    compares++;
    if (got !== want)
    begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, want);
    end
  endtask
  task automatic cmpq(input logic [7:0] q[$]);
    chk(q.size(), exp.size(), "byte count");
    foreach (exp[i]) chk(q[i], exp[i], "byte");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(posedge mclk_i);
    r = reg_rdata_o;
  endtask
  task automatic p2(input logic [15:0] v);
    fr.push_back(v[15:8]);
    fr.push_back(v[7:0]);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic rx_frame(input logic en, input logic md, input int tags, input logic snap);
    int s;
    logic [15:0] v;
    logic [31:0] sw;
    fr.delete();
    repeat (12) fr.push_back(rb());
    // each tag is its identifier followed by its control word
    repeat (tags)
    begin
      p2(vr);
      p2({rb(), rb()});
    end
    p2(snap ? 16'h0040 : 16'h0800);
    if (snap) repeat (8) fr.push_back(rb());
    repeat (9 + rb() % 33) fr.push_back(rb());
    s = !md ? 14 : tags > 2 ? 22 : 14 + 4 * tags + (snap ? 8 : 0);
    v = csum(s, fr.size());
    sw = {rb(), rb(), rb(), rb()};
    sw[29:16] = 14'(fr.size() + 4);
    repeat (4) fr.push_back(rb());
    exp = fr;
    if (en) exp.push_back(v[7:0]);
    if (en) exp.push_back(v[15:8]);
    if (en) nrx++;
    foreach (fr[i]) u_far.rx_put(fr[i], i + 4 >= fr.size());
    u_far.rx_end(sw);
    while (stq.size() == 0) @(posedge mclk_i);
    cmpq(rq);
    chk(stq[0], en ? sw + 32'h0002_0000 : sw, "status");
    rq.delete();
    stq.delete();
  endtask
  task automatic tx_pkt(input logic en, input logic fs, input logic ck, input logic ones);
    int n, sp, lc;
    logic [63:0] c;
    logic [31:0] pre;
    logic [15:0] v;
    // all-ones even span folds to ffffh, so the zero result is hit for sure
    n = ones ? 32 : 24 + rb() % 40;
    sp = ones ? 14 : 14 + rb() % (n - 18);
    lc = 14 + rb() % (n - 19);
    pre = {4'h0, 12'(lc), 4'h0, 12'(sp)};
    c = {rb(), rb(), rb(), rb(), rb(), rb(), rb(), rb()};
    c[13] = fs;
    c[46] = ck;
    fr.delete();
    repeat (n) fr.push_back(ones ? 8'hff : rb());
    exp.delete();
    for (int i = 0; i < 8; i++) exp.push_back(c[8 * i +: 8]);
    foreach (exp[i]) u_far.tx_put(exp[i], i == 0, 1'b0);
    if (en && fs && ck) for (int i = 0; i < 4; i++) u_far.tx_put(pre[8 * i +: 8], 0, 0);
    foreach (fr[i]) u_far.tx_put(fr[i], 1'b0, i == n - 1);
    v = ~csum(sp, n);
    if (en && fs && ck) ntx++;
    if (en && fs && ck) fr[lc] = v[7:0];
    if (en && fs && ck) fr[lc + 1] = v[15:8];
    foreach (fr[i]) exp.push_back(fr[i]);
    while (tq.size() < exp.size()) @(posedge mclk_i);
    repeat (3) @(posedge mclk_i);
    cmpq(tq);
    chk(tfq[0], 2'b10, "first flag");
    chk(tfq[$], 2'b01, "last flag");
    tq.delete();
    tfq.delete();
  endtask
  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {fails, compares, cyc, nrx, ntx} = '0;
    lfsr = 32'h85bd;
    {rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {1'b1, 42'h0};
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(8'h00);
    chk(r, 32'h0, "control reset");
    rd(8'h04);
    chk(r, 32'h8100, "tag type reset");
    vr = {1'b1, 7'(rb()), rb()};
    wr(8'h04, {16'h0, vr});
    wr(8'h40, 32'hffff_ffff);
    rd(8'h04);
    chk(r, {16'h0, vr}, "tag type");
    rd(8'h40);
    chk(r, 32'h0, "unmapped");
    for (int i = 0; i < 24; i++)
    begin
      r = {rb(), rb()} | ((i % 3 == 0) ? 32'h0061 : 32'h0) | ((i < 8) ? 32'h000c : 32'h0);
      u_far.slow = r[7];
      // paths are idle here and pad stripping never exists on this side
      cw = {14'h0, r[1], r[0], 14'h0, r[3], r[2]};
      wr(8'h00, cw);
      rx_frame(r[2], r[3], i % 4, r[4]);
      tx_pkt(r[0], r[5], r[6], i == 3);
      rd(8'h00);
      chk(r, cw, "control readback");
      $display("test %0d done", i);
    end
    rd(8'h08);
    chk(r, {16'(ntx), 16'(nrx)}, "sum counts");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
